/* edge_sync.sv */
// Purpose: Two-flop synchroniser with edge detection for one link line
// Assumes: Input is asynchronous to sys_clk
// Notes: Edge pulses are one sys_clk long
`timescale 1ns/1ns
module edge_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic async_in,
  input wire logic rst_level,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= rst_level;
      sync_q <= rst_level;
      prev_q <= rst_level;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Flops reset to the line's idle level, so no false edge follows reset
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // edge_sync

/* speakerphone_serial_control_port_tb.sv */
// Purpose: Self-checking bench for host and device ends of the control link
// Assumes: Host half period shortened to 8 cycles
// Notes: Outputs judged against a queue of expected values
`timescale 1ns/1ns
module speakerphone_serial_control_port_tb import spkr_ctl_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_v = 1'b0;
  logic chip_disable_input = 1'b0;
  logic [4:0] det = 5'h00;
  logic [7:0] rd_data, control_word;
  logic [3:0] volume_field, rx_volume;
  logic [1:0] mode_field, atten_state, s_mdl;
  logic mic_mute_bit, range_select_bit, rx_gain_reduce;
  logic [7:0] w_mdl = 8'h00;
  logic [7:0] q_rd[$];
  logic [22:0] q_out[$];
  int n_mismatch = 0;
  int n_tests = 0;
  event chk_ev;
  spkr_link_if link ();
  always #5 sys_clk = ~sys_clk;
  spkr_host #(.HALF_CYC(8)) u_spkr_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  spkr_device u_spkr_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .chip_disable_input(chip_disable_input),
    .tx_louder(det[4]), .tx_speech(det[3]), .rx_speech(det[2]), .dial_tone(det[1]), .supply_sag_gain_control(det[0]),
    .volume_field(volume_field), .rx_volume(rx_volume), .mic_mute_bit(mic_mute_bit), .range_select_bit(range_select_bit),
    .mode_field(mode_field), .atten_state(atten_state), .rx_gain_reduce(rx_gain_reduce), .control_word(control_word));
  spkr_link_props u_spkr_link_props (.sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(link.ser_clk),
    .ser_data(link.ser_data), .load_strobe(link.load_strobe), .chip_disable_input(chip_disable_input),
    .control_word(control_word));
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [22:0] e, input logic [22:0] g);
    n_tests++;
    if (e !== g) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(posedge sys_clk) begin
    if (rd_v) cmp({15'h0000, q_rd.pop_front()}, {15'h0000, rd_data});
    rd_v <= rd_en;
  end
  always @(chk_ev) cmp(q_out.pop_front(), {control_word, mode_field, range_select_bit, mic_mute_bit,
    volume_field, rx_volume, atten_state, rx_gain_reduce});
  task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= d;
  endtask
  task automatic wait_strobe(input logic lvl);
    int k = 0;
    while (link.load_strobe !== lvl && k < 400) begin
      bus(1'b0, 1'b0, 2'h0, 8'h00);
      k++;
    end
    if (link.load_strobe !== lvl) begin
      n_mismatch++;
      close_out();
    end
  endtask
  function automatic logic [1:0] nxt(input logic [1:0] m, input logic [1:0] s, input logic [4:0] i);
    if (m != 2'h0) return (m == 2'h1) ? ST_RECEIVE : (m == 2'h2) ? ST_IDLE : ST_TRANSMIT;
    if (i[3] || i[2]) return i[4] ? ST_TRANSMIT : ST_RECEIVE;
    return (s == ST_RECEIVE && i[1]) ? ST_RECEIVE : ST_IDLE;
  endfunction
  task automatic send(input logic [7:0] w, input logic [4:0] i, input logic c);
    det <= i;
    chip_disable_input <= c;
    bus(1'b1, 1'b0, 2'h0, w);
    bus(1'b1, 1'b0, 2'h1, 8'h01);
    bus(1'b0, 1'b1, 2'h2, 8'h00);
    q_rd.push_back(8'h01);
    wait_strobe(1'b0);
    wait_strobe(1'b1);
    repeat (12) bus(1'b0, 1'b0, 2'h0, 8'h00);
    chip_disable_input <= 1'b0;
    repeat (8) bus(1'b0, 1'b0, 2'h0, 8'h00);
    // Disabled device sits in idle whatever the word says
    s_mdl = c ? ST_IDLE : nxt(w_mdl[7:6], s_mdl, i);
    w_mdl = c ? 8'h00 : w;
    s_mdl = nxt(w_mdl[7:6], s_mdl, i);
    bus(1'b0, 1'b1, 2'h0, 8'h00);
    q_rd.push_back(w);
    bus(1'b0, 1'b1, 2'h2, 8'h00);
    q_rd.push_back(8'h00);
    bus(1'b0, 1'b1, 2'h3, 8'h00);
    q_rd.push_back(8'h00);
    bus(1'b0, 1'b0, 2'h0, 8'h00);
    q_out.push_back({w_mdl, w_mdl[7:6], w_mdl[5], w_mdl[4], w_mdl[3:0], (s_mdl == ST_RECEIVE) ? w_mdl[3:0] : 4'h0,
      s_mdl, i[0] && s_mdl == ST_RECEIVE});
    ->chk_ev;
  endtask
  initial begin
    void'($urandom(32'hd4a3));
    s_mdl = ST_IDLE;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, 1'b0, 2'h0, 8'h00);
    send(8'h4a, 5'b00010, 1'b0);
    send(8'h0a, 5'b00010, 1'b0);
    send(8'h0a, 5'b00000, 1'b0);
    for (int j = 0; j < 32; j++) send({j[1:0], 6'($urandom)}, 5'($urandom), 1'b0);
    send(8'hff, 5'b00000, 1'b1);
    send(8'h5c, 5'b00000, 1'b0);
    rst_n <= 1'b0;
    repeat (2) bus(1'b0, 1'b0, 2'h0, 8'h00);
    rst_n <= 1'b1;
    repeat (4) bus(1'b0, 1'b0, 2'h0, 8'h00);
    q_out.push_back(23'h00_0000);
    ->chk_ev;
    repeat (2) bus(1'b0, 1'b0, 2'h0, 8'h00);
    close_out();
  end
  // Cuts a hang short
  initial begin
    #500_000;
    n_mismatch++;
    close_out();
  end
endmodule // speakerphone_serial_control_port_tb

/* spkr_ctl_pkg.sv */
// Purpose: Shared constants and types for the speakerphone serial control port
// Assumes: One system clock at 100 MHz, link clock made by the host end
// Notes: Control word fields, mode and state encodings, link timing
package spkr_ctl_pkg;
  localparam int WORD_BITS = 8;
  localparam int VOL_LSB = 0;
  localparam int VOL_MSB = 3;
  localparam int MUTE_POS = 4;
  localparam int RANGE_POS = 5;
  localparam int MODE_LSB = 6;
  localparam int MODE_MSB = 7;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [3:0] VOL_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'h0,
    MODE_RECEIVE = 2'h1,
    MODE_IDLE = 2'h2,
    MODE_TRANSMIT = 2'h3
  } mode_t;

  // Two-bit code of the selected attenuator state
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RECEIVE = 2'h1,
    ST_TRANSMIT = 2'h2
  } atten_state_t;

  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int LINK_MAX_HZ = 1_000_000;
  // Half period of the generated serial clock, rounded up so the rate never exceeds the limit
  localparam int LINK_HALF_CYC = (SYS_CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BITS_LAST = 4'h7;
endpackage

/* spkr_device.sv */
// Purpose: Speakerphone device end: serial control word port and mode decision
// Assumes: Host keeps to the link timing; analog detectors arrive as digital levels
// Notes: Registers cleared by reset and on release of chip disable
// Function
// - Eight bits, MSB first, volume LSB last
// - Sample data on serial clock rising edge
// - Host limits serial clock to 1 MHz
// - Strobe idles high, low while shifting
// - Strobe rising edge loads active word
// - No address, framing or handshake used
// - Strobe low before first falling clock
// - Strobe preferably high between transfers
// - Strobe rises before next rising clock
// - Volume 0000 loudest, 1111 quietest
// - Volume effective only in receive state
// - Mute bit one mutes microphone amplifier
// - Range bit: 0 full, 1 half
// - Mode field: auto, receive, idle, transmit
// - Auto: comparator picks transmit or receive
// - Auto: no speech both paths gives idle
// - Dial tone in receive blocks idle
// - Six inputs feed attenuator control
// - Reset clears word, discards writes
// - Word stays zero until new load
// - Chip disable ignores all transfers
// - Chip disable release clears word
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
module spkr_device
  import spkr_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  spkr_link_if.device link,
  input wire logic chip_disable_input,
  input wire logic tx_louder,
  input wire logic tx_speech,
  input wire logic rx_speech,
  input wire logic dial_tone,
  input wire logic supply_sag_gain_control,
  output logic [3:0] volume_field,
  output logic [3:0] rx_volume,
  output logic mic_mute_bit,
  output logic range_select_bit,
  output logic [1:0] mode_field,
  output logic [1:0] atten_state,
  output logic rx_gain_reduce,
  output logic [7:0] control_word
);
  logic clk_rise;
  logic strobe_level;
  logic strobe_rise;
  logic data_level;
  logic cd_meta_q;
  logic cd_sync_q;
  logic cd_prev_q;
  logic tx_louder_meta_q, tx_louder_q;
  logic tx_speech_meta_q, tx_speech_q;
  logic rx_speech_meta_q, rx_speech_q;
  logic dial_meta_q, dial_q;
  logic sag_meta_q, sag_q;
  logic [7:0] shift_q;
  logic [7:0] word_q;
  atten_state_t state_q;
  atten_state_t state_d;

  edge_sync u_clk_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(link.ser_clk),
    .rst_level(1'b0),
    .level(),
    .rise(clk_rise),
    .fall()
  );

  edge_sync u_strobe_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(link.load_strobe),
    .rst_level(1'b1),
    .level(strobe_level),
    .rise(strobe_rise),
    .fall()
  );

  edge_sync u_data_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(link.ser_data),
    .rst_level(1'b0),
    .level(data_level),
    .rise(),
    .fall()
  );

  // Chip disable and detector levels come from outside the clock domain
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cd_meta_q <= 1'b0;
      cd_sync_q <= 1'b0;
      cd_prev_q <= 1'b0;
      tx_louder_meta_q <= 1'b0;
      tx_louder_q <= 1'b0;
      tx_speech_meta_q <= 1'b0;
      tx_speech_q <= 1'b0;
      rx_speech_meta_q <= 1'b0;
      rx_speech_q <= 1'b0;
      dial_meta_q <= 1'b0;
      dial_q <= 1'b0;
      sag_meta_q <= 1'b0;
      sag_q <= 1'b0;
    end else begin
      cd_meta_q <= chip_disable_input;
      cd_sync_q <= cd_meta_q;
      cd_prev_q <= cd_sync_q;
      tx_louder_meta_q <= tx_louder;
      tx_louder_q <= tx_louder_meta_q;
      tx_speech_meta_q <= tx_speech;
      tx_speech_q <= tx_speech_meta_q;
      rx_speech_meta_q <= rx_speech;
      rx_speech_q <= rx_speech_meta_q;
      dial_meta_q <= dial_tone;
      dial_q <= dial_meta_q;
      sag_meta_q <= supply_sag_gain_control;
      sag_q <= sag_meta_q;
    end
  end

  // Shift register: one bit per serial clock rise while the strobe is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_q <= WORD_RESET;
    end else if (cd_sync_q) begin
      shift_q <= WORD_RESET;
    end else if (clk_rise && !strobe_level) begin
      // Edge-only sampling: no address or frame
      shift_q <= {shift_q[WORD_BITS-2:0], data_level};
    end
  end

  // Active word; only the last eight bits before the strobe rise count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      word_q <= WORD_RESET;
    end else if (cd_prev_q && !cd_sync_q) begin
      word_q <= WORD_RESET;
    end else if (strobe_rise && !cd_sync_q) begin
      // Loads blocked while disabled; old word kept until release
      word_q <= shift_q;
    end
  end

  assign control_word = word_q;
  assign volume_field = word_q[VOL_MSB:VOL_LSB];
  assign mic_mute_bit = word_q[MUTE_POS];
  assign range_select_bit = word_q[RANGE_POS];
  assign mode_field = word_q[MODE_MSB:MODE_LSB];

  // Mode decision from comparator, monitors, dial tone and the word
  always_comb begin
    state_d = state_q;
    case (mode_t'(mode_field))
      MODE_RECEIVE: state_d = ST_RECEIVE;
      MODE_IDLE: state_d = ST_IDLE;
      MODE_TRANSMIT: state_d = ST_TRANSMIT;
      MODE_AUTO: begin
        if (tx_speech_q || rx_speech_q) begin
          state_d = tx_louder_q ? ST_TRANSMIT : ST_RECEIVE;
        end else if (state_q == ST_RECEIVE && dial_q) begin
          state_d = ST_RECEIVE;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (cd_sync_q) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign atten_state = state_q;

  // Shared receive decode for both receive-only outputs
  function automatic logic in_receive(input atten_state_t st);
    return st == ST_RECEIVE;
  endfunction

  // Volume reaches the attenuator only in receive; loudest otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_volume <= VOL_RESET;
    end else begin
      rx_volume <= in_receive(state_q) ? volume_field : VOL_RESET;
    end
  end

  // Supply sag lowers receive gain in receive only; lags state by one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_gain_reduce <= 1'b0;
    end else begin
      rx_gain_reduce <= sag_q && in_receive(state_q);
    end
  end
endmodule // spkr_device

/* spkr_host.sv */
// Purpose: Host end: writes one control word over the three-wire link
// Assumes: Software loads word and start over a plain register port
// Notes: Serial clock made by divider, at most 1 MHz
`timescale 1ns/1ns
module spkr_host
  import spkr_ctl_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  spkr_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data
);
  localparam logic [1:0] ADDR_WORD = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW = 4'b0010,
    H_HIGH = 4'b0100,
    H_DONE = 4'b1000
  } host_state_t;

  host_state_t st_q;
  logic [7:0] word_q;
  logic [7:0] shift_q;
  logic [BIT_CNT_W-1:0] bit_q;
  logic [15:0] div_q;
  logic tick;
  logic start;
  logic sclk_q;
  logic strobe_q;
  logic busy;

  assign start = wr_en && addr == ADDR_CTRL && wr_data[0];
  assign busy = st_q != H_IDLE;
  assign tick = div_q == 16'(HALF_CYC - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q == H_IDLE) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      word_q <= WORD_RESET;
    end else if (wr_en && addr == ADDR_WORD) begin
      word_q <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        ADDR_WORD: rd_data <= word_q;
        ADDR_STATUS: rd_data <= {7'h00, busy};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // Clock idles low; strobe low during shifting, high between words
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
      sclk_q <= 1'b0;
      strobe_q <= 1'b1;
      shift_q <= WORD_RESET;
      bit_q <= '0;
    end else begin
      case (st_q)
        H_IDLE: if (start) begin
          strobe_q <= 1'b0;
          shift_q <= word_q;
          bit_q <= '0;
          st_q <= H_LOW;
        end
        H_LOW: if (tick) begin
          sclk_q <= 1'b1;
          st_q <= H_HIGH;
        end
        H_HIGH: if (tick) begin
          sclk_q <= 1'b0;
          if (bit_q == BITS_LAST) begin
            st_q <= H_DONE;
          end else begin
            shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            st_q <= H_LOW;
          end
        end
        H_DONE: if (tick) begin
          // Clock stopped before raising the strobe
          strobe_q <= 1'b1;
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.ser_clk = sclk_q;
  assign link.ser_data = shift_q[WORD_BITS-1];
  assign link.load_strobe = strobe_q;
endmodule // spkr_host

/* spkr_link_if.sv */
// Purpose: Three-wire serial link between host controller and speakerphone device
// Assumes: Host drives all three lines; device only listens
// Notes: Load strobe idles high
`timescale 1ns/1ns
interface spkr_link_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  modport host (output ser_clk, output ser_data, output load_strobe);
  modport device (input ser_clk, input ser_data, input load_strobe);
endinterface // spkr_link_if

/* spkr_link_props.sv */
// Purpose: Link timing and word load checks
// Assumes: Host built with a half period of 8 cycles
// Notes: Sees the link wires and the device word
`timescale 1ns/1ns
module spkr_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic chip_disable_input,
  input wire logic [7:0] control_word
);
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk) begin
    if (!rst_n || load_strobe) begin
      cnt_q <= 4'h0;
    end else if ($rose(ser_clk)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Own copy of the frame, to judge the loaded word
  always_ff @(posedge sys_clk) begin
    if ($rose(ser_clk) && !load_strobe) begin
      sh_q <= {sh_q[6:0], ser_data};
    end
  end
  AST_IDLE_CLK_LOW:
    assert property (load_strobe |-> !ser_clk) else $error("clock moved outside a frame");
  AST_HIGH_TIME:
    assert property ($rose(ser_clk) |-> ser_clk [*8]) else $error("clock high too short");
  AST_LOW_TIME:
    assert property ($fell(ser_clk) |-> !ser_clk [*8]) else $error("clock low too short");
  AST_DATA_HOLD:
    assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data)) else $error("data moved with clock high");
  AST_FIRST_EDGE:
    assert property ($fell(load_strobe) |-> !ser_clk ##[1:16] ser_clk) else $error("no clock after strobe fall");
  AST_EIGHT_BITS:
    assert property ($rose(load_strobe) |-> cnt_q == 4'h8) else $error("frame not eight bits");
  AST_STROBE_END:
    assert property (cnt_q == 4'h8 && $fell(ser_clk) |-> ##[1:16] load_strobe) else $error("strobe late");
  AST_WORD_LOAD:
    assert property ($rose(load_strobe) && !chip_disable_input |-> ##[2:8] control_word == sh_q)
      else $error("word not loaded");
  AST_CD_BLOCK:
    assert property (chip_disable_input [*5] |-> $stable(control_word)) else $error("word changed while disabled");
  AST_CD_CLEAR:
    assert property ($fell(chip_disable_input) |-> ##[1:8] control_word == 8'h00) else $error("word kept on enable");
  AST_RESET_CLEAR:
    assert property ($rose(rst_n) |-> control_word == 8'h00) else $error("word kept over reset");
  cover property ($rose(load_strobe));
  cover property ($fell(chip_disable_input));
  cover property ($rose(load_strobe) && sh_q[7:6] == 2'h0);
endmodule // spkr_link_props
